// File: design/adc_conversion_control.sv
// converter control, prescaler, triggering and AHB-Lite register slave
`timescale 1ns/1ps

// Function
// - channel select latched only between conversions
// - codes pick single, differential, bandgap, ground
// - differential codes 8 to 15 also pick amplifier gain
// - enable bit powers converter; clearing aborts
// - single mode: one conversion per go write
// - free running: first go, then continuous
// - first conversion 25 cycles, later 13
// - go bit reads one while converting
// - writing zero to go is ignored
// - auto trigger on selected flag rising edge
// - done flag set when conversion completes
// - interrupt when flag, enable, global enable
// - vector acknowledge clears done flag
// - writing one clears done flag
// - prescaler divides system clock 2 to 128
// - source zero is free running, no trigger
// - source switch to set flag triggers
// - low byte read locks result until high
module adc_conversion_control #(
    parameter int RESULT_W = 10
) (
    // clock and reset
    input  wire logic                        sys_clk_in,
    input  wire logic                        rst_n_in,
    // ahb-lite slave
    input  wire logic                        hsel_in,
    input  wire logic [31:0]                 haddr_in,
    input  wire logic [1:0]                  htrans_in,
    input  wire logic                        hwrite_in,
    input  wire logic [2:0]                  hsize_in,
    input  wire logic [31:0]                 hwdata_in,
    input  wire logic                        hready_in,
    output logic      [31:0]                 hrdata_out,
    output logic                             hreadyout_out,
    output logic                             hresp_out,
    // analog converter side
    input  wire logic [RESULT_W-1:0]         conv_result_in,
    output logic                             conv_power_out,
    output logic                             conv_sample_out,
    output logic                             conv_clk_tick_out,
    output logic                             conv_busy_out,
    output adc_ctrl_pkg::input_route_t       route_out,
    // core and peripheral side
    input  wire logic [adc_ctrl_pkg::TRIG_N-1:0] trigger_flags_in,
    input  wire logic                        global_irq_enable_in,
    input  wire logic                        done_vector_ack_in,
    output logic                             irq_out
);
    import adc_ctrl_pkg::*;

    if (RESULT_W < 1 || RESULT_W > 16) begin : g_bad_result_w
        $error("RESULT_W must lie between 1 and 16");
    end

    ctrl_status_t          ctrl;
    logic                  conv_on;
    logic                  auto_on;
    logic                  done_irq_on;
    logic [2:0]            div_sel;
    logic                  go_bit;
    logic                  done_bit;
    logic [4:0]            channel_gain_select;
    logic [2:0]            trigger_source_select;
    logic [4:0]            active_select;
    logic [RESULT_W-1:0]   result;
    logic                  result_locked;
    logic [IRQ_W-1:0]      irq_status;
    logic [IRQ_W-1:0]      irq_mask;
    conv_state_t           state;
    logic                  first_pending;
    logic                  first_conv;
    logic [4:0]            conv_cnt;
    logic [6:0]            div_cnt;
    logic                  trig_level_prev;
    logic                  conv_end_d;
    ahb_dphase_t           dphase;
    logic                  rd_wait;

    function automatic logic [6:0] div_mask(input logic [2:0] sel);
        case (sel)
            3'h0, 3'h1: div_mask = 7'h01;
            3'h2:       div_mask = 7'h03;
            3'h3:       div_mask = 7'h07;
            3'h4:       div_mask = 7'h0F;
            3'h5:       div_mask = 7'h1F;
            3'h6:       div_mask = 7'h3F;
            default:    div_mask = 7'h7F;
        endcase
    endfunction

    function automatic input_route_t decode_route(input logic [4:0] code);
        input_route_t r;
        r = '{kind: SRC_DIFF, pos: code[2:0], neg: 3'h0, gain: GAIN_1X};
        if (code[4:3] == 2'b00) begin
            r.kind = SRC_SINGLE;
        end else if (code == 5'h1E) begin
            r.kind = SRC_BANDGAP;
        end else if (code == 5'h1F) begin
            r.kind = SRC_GROUND;
        end else if (code[4:3] == 2'b01) begin
            r.pos  = {1'b0, code[2], code[0]};
            r.neg  = code[2] ? 3'h2 : 3'h0;
            r.gain = code[1] ? GAIN_200X : GAIN_10X;
        end else begin
            r.neg = code[3] ? 3'h2 : 3'h1;
        end
        decode_route = r;
    endfunction

    // bus decode
    logic addr_take;
    logic wr_now;
    logic wr_ctrl;
    logic wr_insel;
    logic wr_trig;
    logic wr_stat;
    logic wr_mask;
    logic rd_low;
    logic rd_high;

    assign addr_take = hsel_in && htrans_in[1] && hready_in;
    assign wr_now    = dphase.valid && dphase.write;
    assign wr_ctrl   = wr_now && (dphase.addr == ADDR_CTRL);
    assign wr_insel  = wr_now && (dphase.addr == ADDR_INSEL);
    assign wr_trig   = wr_now && (dphase.addr == ADDR_TRIGSEL);
    assign wr_stat   = wr_now && (dphase.addr == ADDR_IRQ_STAT);
    assign wr_mask   = wr_now && (dphase.addr == ADDR_IRQ_MASK);
    assign rd_low    = rd_wait && (dphase.addr == ADDR_RES_LOW);
    assign rd_high   = rd_wait && (dphase.addr == ADDR_RES_HIGH);

    ctrl_status_t wr_val;
    assign wr_val = ctrl_status_t'(hwdata_in[7:0]);
    // each field is written by one owner process
    assign ctrl   = '{conv_on, go_bit, auto_on, done_bit, done_irq_on,
                      div_sel};

    // conversion control terms
    logic       on_next;
    logic       div_tick;
    logic       go_write;
    logic       trig_level;
    logic       trig_edge;
    logic       start_req;
    logic       conv_end;
    logic       abort;
    logic [4:0] conv_len;

    assign on_next  = wr_ctrl ? wr_val.converter_on : ctrl.converter_on;
    assign div_tick = ctrl.converter_on
                      && ((div_cnt & div_mask(ctrl.clock_divider_select))
                          == div_mask(ctrl.clock_divider_select));
    assign go_write = wr_ctrl && wr_val.conversion_go;
    assign trig_level = trigger_flags_in[trigger_source_select];
    // free running restarts from the previous completion only
    assign trig_edge = ctrl.auto_trigger_on
                       && ((trigger_source_select == TRIG_FREE_RUN)
                           ? conv_end_d
                           : (trig_level && !trig_level_prev));
    assign start_req = on_next && (state == CONV_IDLE)
                       && (go_write || trig_edge);
    assign conv_len  = first_conv ? CONV_FIRST_LEN : CONV_NORMAL_LEN;
    assign abort     = (state == CONV_RUN) && !on_next;
    assign conv_end  = (state == CONV_RUN) && on_next && div_tick
                       && (conv_cnt == conv_len - 5'h01);

    // ahb-lite slave: writes zero-wait, reads one wait state
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dphase        <= '0;
            rd_wait       <= 1'b0;
            hreadyout_out <= 1'b1;
            hrdata_out    <= 32'h0000_0000;
            hresp_out     <= 1'b0;
        end else begin
            rd_wait <= addr_take && !hwrite_in;
            if (hreadyout_out) begin
                dphase.valid <= addr_take;
                dphase.write <= hwrite_in;
                dphase.addr  <= haddr_in[7:0];
            end else begin
                dphase.valid <= 1'b0;
            end
            hreadyout_out <= !(addr_take && !hwrite_in);
            if (rd_wait) begin
                if (dphase.addr == ADDR_CTRL) begin
                    hrdata_out <= {24'h00_0000, ctrl};
                end else if (dphase.addr == ADDR_INSEL) begin
                    hrdata_out <= {27'h000_0000, channel_gain_select};
                end else if (dphase.addr == ADDR_TRIGSEL) begin
                    hrdata_out <= {29'h0000_0000, trigger_source_select};
                end else if (dphase.addr == ADDR_RES_LOW) begin
                    hrdata_out <= 32'({result} & 32'h0000_00FF);
                end else if (dphase.addr == ADDR_RES_HIGH) begin
                    hrdata_out <= 32'({result} >> 8);
                end else if (dphase.addr == ADDR_IRQ_STAT) begin
                    hrdata_out <= {29'h0000_0000, irq_status};
                end else if (dphase.addr == ADDR_IRQ_MASK) begin
                    hrdata_out <= {29'h0000_0000, irq_mask};
                end else begin
                    hrdata_out <= 32'h0000_0000;
                end
            end
        end
    end

    // software-owned settings
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            conv_on                   <= CTRL_RESET[7];
            auto_on                   <= CTRL_RESET[5];
            done_irq_on               <= CTRL_RESET[3];
            div_sel                   <= CTRL_RESET[2:0];
            channel_gain_select       <= INSEL_RESET;
            trigger_source_select     <= TRIGSEL_RESET;
            irq_mask                  <= '0;
        end else begin
            if (wr_ctrl) begin
                conv_on     <= wr_val.converter_on;
                auto_on     <= wr_val.auto_trigger_on;
                done_irq_on <= wr_val.done_irq_enable;
                div_sel     <= wr_val.clock_divider_select;
            end
            if (wr_insel) begin
                channel_gain_select <= hwdata_in[4:0];
            end
            if (wr_trig) begin
                trigger_source_select <= hwdata_in[2:0];
            end
            if (wr_mask) begin
                irq_mask <= hwdata_in[IRQ_W-1:0];
            end
        end
    end

    // prescaler and trigger edge history
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_cnt           <= 7'h00;
            conv_clk_tick_out <= 1'b0;
            trig_level_prev   <= 1'b0;
            conv_end_d        <= 1'b0;
        end else begin
            div_cnt           <= ctrl.converter_on ? div_cnt + 7'h01 : 7'h00;
            conv_clk_tick_out <= div_tick;
            trig_level_prev   <= trig_level;
            conv_end_d        <= conv_end;
        end
    end

    // conversion sequencer
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state           <= CONV_IDLE;
            go_bit          <= CTRL_RESET[6];
            first_pending   <= 1'b0;
            first_conv      <= 1'b0;
            conv_cnt        <= 5'h00;
            active_select   <= INSEL_RESET;
            conv_sample_out <= 1'b0;
            conv_busy_out   <= 1'b0;
            conv_power_out  <= 1'b0;
            route_out       <= decode_route(INSEL_RESET);
        end else begin
            conv_sample_out <= start_req;
            conv_power_out  <= on_next;
            if (!ctrl.converter_on && on_next) begin
                first_pending <= 1'b1;
            end
            case (state)
                CONV_IDLE: begin
                    if (start_req) begin
                        state              <= CONV_RUN;
                        go_bit             <= 1'b1;
                        conv_busy_out      <= 1'b1;
                        first_conv         <= first_pending
                                              || !ctrl.converter_on;
                        first_pending      <= 1'b0;
                        conv_cnt           <= 5'h00;
                        active_select      <= wr_insel ? hwdata_in[4:0]
                                              : channel_gain_select;
                        route_out          <= decode_route(
                            wr_insel ? hwdata_in[4:0]
                                     : channel_gain_select);
                    end
                end
                CONV_RUN: begin
                    if (abort || conv_end) begin
                        state              <= CONV_IDLE;
                        go_bit             <= 1'b0;
                        conv_busy_out      <= 1'b0;
                    end else if (div_tick) begin
                        conv_cnt <= conv_cnt + 5'h01;
                    end
                end
                default: state <= CONV_IDLE;
            endcase
        end
    end

    // result capture and read-order lock
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            result        <= '0;
            result_locked <= 1'b0;
        end else begin
            if (conv_end && !result_locked) begin
                result <= conv_result_in;
            end
            if (rd_low) begin
                result_locked <= 1'b1;
            end else if (rd_high) begin
                result_locked <= 1'b0;
            end
        end
    end

    // done flag and sticky interrupt status, set wins over clear
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_bit                  <= CTRL_RESET[4];
            irq_status                <= '0;
            irq_out                   <= 1'b0;
        end else begin
            if (conv_end) begin
                done_bit <= 1'b1;
            end else if (done_vector_ack_in) begin
                done_bit <= 1'b0;
            end else if (wr_ctrl && wr_val.conversion_done_flag) begin
                done_bit <= 1'b0;
            end
            for (int i = 0; i < IRQ_W; i++) begin
                if ((i == IRQ_DONE && conv_end)
                    || (i == IRQ_ABORT && abort)
                    || (i == IRQ_OVERRUN && conv_end && result_locked)) begin
                    irq_status[i] <= 1'b1;
                end else if (wr_stat && hwdata_in[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
            irq_out <= (ctrl.conversion_done_flag && ctrl.done_irq_enable
                        && global_irq_enable_in)
                       || |(irq_status & irq_mask);
        end
    end

    // ticks counted across the running conversion
    logic [5:0] chk_ticks;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            chk_ticks <= 6'h00;
        end else if (state == CONV_IDLE) begin
            chk_ticks <= 6'h00;
        end else if (div_tick) begin
            chk_ticks <= chk_ticks + 6'h01;
        end
    end

    chk_end_len: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        conv_end |-> (chk_ticks + 6'h01)
                     == (first_conv ? 6'h19 : 6'h0D))
        else $error("conversion length wrong");

    chk_go_flag_sync: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        conv_end |=> !ctrl.conversion_go && ctrl.conversion_done_flag
                     && !conv_busy_out)
        else $error("go and flag not updated together");

    chk_off_aborts: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (state == CONV_RUN && wr_ctrl && !wr_val.converter_on)
        |=> state == CONV_IDLE && !ctrl.conversion_go && !conv_power_out)
        else $error("disable did not abort");

    chk_go_zero: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (state == CONV_RUN && wr_ctrl && wr_val.converter_on
         && !wr_val.conversion_go && !conv_end)
        |=> ctrl.conversion_go)
        else $error("zero write stopped conversion");

    chk_chan_hold: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (state == CONV_RUN) ##1 (state == CONV_RUN)
        |-> $stable(active_select) && $stable(route_out))
        else $error("channel changed mid conversion");

    chk_fast_div: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        div_tick && ctrl.clock_divider_select[2:1] == 2'b00
        && $stable(ctrl.clock_divider_select) && ctrl.converter_on
        |=> !div_tick ##1 (div_tick || !ctrl.converter_on
                          || $changed(ctrl.clock_divider_select)))
        else $error("divide by two spacing wrong");

    chk_flag_clear: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (done_vector_ack_in || (wr_ctrl && wr_val.conversion_done_flag))
        && !conv_end |=> !ctrl.conversion_done_flag)
        else $error("done flag not cleared");

    chk_irq_level: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        ctrl.conversion_done_flag && ctrl.done_irq_enable
        && global_irq_enable_in |=> irq_out)
        else $error("interrupt not raised");

    chk_lock_hold: assert property (
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        conv_end && result_locked |=> $stable(result)
                                      && irq_status[IRQ_OVERRUN])
        else $error("locked result overwritten");

endmodule // adc_conversion_control

// File: shared/adc_ctrl_pkg.sv
// constants, types and register map of the converter control block
package adc_ctrl_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_INSEL    = 8'h04;
    localparam logic [7:0] ADDR_TRIGSEL  = 8'h08;
    localparam logic [7:0] ADDR_RES_LOW  = 8'h0C;
    localparam logic [7:0] ADDR_RES_HIGH = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

    // reset values
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [4:0] INSEL_RESET   = 5'h00;
    localparam logic [2:0] TRIGSEL_RESET = 3'h0;

    // conversion lengths in converter clock cycles
    localparam logic [4:0] CONV_FIRST_LEN  = 5'h19;
    localparam logic [4:0] CONV_NORMAL_LEN = 5'h0D;

    // trigger source code that means free running
    localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
    localparam int         TRIG_N        = 8;

    // sticky interrupt status bits
    localparam int IRQ_W       = 3;
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_ABORT   = 1;
    localparam int IRQ_OVERRUN = 2;

    typedef struct packed {
        logic       converter_on;
        logic       conversion_go;
        logic       auto_trigger_on;
        logic       conversion_done_flag;
        logic       done_irq_enable;
        logic [2:0] clock_divider_select;
    } ctrl_status_t;

    typedef enum logic [1:0] {
        SRC_SINGLE  = 2'b00,
        SRC_DIFF    = 2'b01,
        SRC_BANDGAP = 2'b10,
        SRC_GROUND  = 2'b11
    } input_kind_t;

    typedef enum logic [1:0] {
        GAIN_1X   = 2'b00,
        GAIN_10X  = 2'b01,
        GAIN_200X = 2'b10
    } gain_t;

    typedef struct packed {
        input_kind_t kind;
        logic [2:0]  pos;
        logic [2:0]  neg;
        gain_t       gain;
    } input_route_t;

    typedef enum logic {
        CONV_IDLE = 1'b0,
        CONV_RUN  = 1'b1
    } conv_state_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } ahb_dphase_t;

endpackage

// File: tb/tb_adc_conversion_control.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_adc_conversion_control;
    import adc_ctrl_pkg::*;
    localparam logic [31:0] YES = 32'h0000_0001;
    logic         sys_clk_in = 1'b0;
    logic         rst_n_in   = 1'b0;
    logic         hsel       = 1'b0;
    logic [31:0]  haddr      = 32'h0000_0000;
    logic [1:0]   htrans     = 2'h0;
    logic         hwrite     = 1'b0;
    logic [31:0]  hwdata     = 32'h0000_0000;
    logic [9:0]   res        = 10'h000;
    logic [7:0]   flags      = 8'h00;
    logic         gie        = 1'b0;
    logic         ack        = 1'b0;
    logic [31:0]  hrdata;
    logic [31:0]  rv;
    logic         hrdy;
    logic         hresp;
    logic         pwr;
    logic         busy;
    logic         irq;
    logic         smp;
    logic         tick;
    logic         bq         = 1'b0;
    logic [9:0]   r1;
    logic [9:0]   r2;
    input_route_t route;
    int           errors     = 0;
    int           cmp_count  = 0;
    int           bcnt       = 0;
    int           blen       = 0;
    int           nconv      = 0;
    int           tcnt       = 0;
    int           nsmp       = 0;
    int           n0;
    int           dv;

    adc_conversion_control dut_u (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hrdy),
        .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
        .conv_result_in(res), .conv_power_out(pwr), .conv_sample_out(smp),
        .conv_clk_tick_out(tick), .conv_busy_out(busy), .route_out(route),
        .trigger_flags_in(flags), .global_irq_enable_in(gie),
        .done_vector_ack_in(ack), .irq_out(irq)
    );

    initial begin
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    // conversion, sample and tick counts, length of the last one
    always @(posedge sys_clk_in) begin
        bq <= busy;
        if (bq === 1'b1 && tick === 1'b1) tcnt <= tcnt + 1;
        if (smp === 1'b1) nsmp <= nsmp + 1;
        if (busy === 1'b1) begin
            if (bcnt == 0) begin
                nconv <= nconv + 1;
                tcnt  <= 0;
            end
            bcnt <= bcnt + 1;
        end else if (bcnt != 0) begin
            blen <= bcnt;
            bcnt <= 0;
        end
    end

    task automatic results();
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic tmo();
        errors++;
        $display("[ERR] %0t wait ran out", $time);
        results();
    endtask

    task automatic rdy(output logic [31:0] d);
        int n;
        for (n = 0; n < 20; n++) begin
            @(negedge sys_clk_in);
            if (hrdy === 1'b1) break;
        end
        if (n == 20) tmo();
        d = hrdata;
        @(posedge sys_clk_in);
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] wd, output logic [31:0] d);
        @(posedge sys_clk_in);
        hsel   <= 1'b1;
        haddr  <= 32'(a);
        htrans <= 2'h2;
        hwrite <= w;
        rdy(d);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= 32'(wd);
        rdy(d);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d, rv);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00, rv);
        chk(rv, 32'(e));
    endtask

    task automatic wb(input logic v);
        int n;
        for (n = 0; n < 4000; n++) begin
            @(negedge sys_clk_in);
            if (busy === v) break;
        end
        if (n == 4000) tmo();
    endtask

    task automatic conv();
        wb(1'b1);
        wb(1'b0);
        @(negedge sys_clk_in);
    endtask

    // prescaler free-runs, so allow one converter clock of start phase
    task automatic len(input int nn);
        chk(32'(blen > (nn - 1) * dv && blen <= nn * dv + 1), YES);
        chk(tcnt, nn);
    endtask

    initial begin
        void'($urandom(38));
        repeat (8) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_INSEL, 8'(INSEL_RESET));
        rd(ADDR_TRIGSEL, 8'(TRIGSEL_RESET));
        wr(8'h1c, 8'hff);
        rd(8'h1c, 8'h00);
        chk(hresp, 32'h0000_0000);
        for (int k = 0; k < 8; k++) begin
            dv = k < 2 ? 2 : 1 << k;
            r1 = 10'($urandom);
            res <= r1;
            wr(ADDR_CTRL, 8'hc0 | 8'(k));
            conv();
            len(25);
            chk(pwr, YES);
            rd(ADDR_CTRL, 8'h90 | 8'(k));
            rd(ADDR_RES_LOW, r1[7:0]);
            rd(ADDR_RES_HIGH, 8'(r1[9:8]));
            wr(ADDR_CTRL, 8'hd0 | 8'(k));
            wb(1'b1);
            rd(ADDR_CTRL, 8'hc0 | 8'(k));
            wr(ADDR_CTRL, 8'h80 | 8'(k));
            wb(1'b0);
            @(negedge sys_clk_in);
            len(13);
            n0 = nconv;
            repeat (40) @(negedge sys_clk_in);
            chk(nconv, n0);
            wr(ADDR_CTRL, 8'h00);
        end
        dv = 2;
        for (int c = 0; c < 32; c++) begin
            wr(ADDR_INSEL, 8'(c));
            wr(ADDR_CTRL, 8'hc0);
            wb(1'b1);
            wr(ADDR_INSEL, 8'(c ^ 31));
            wb(1'b0);
            chk(route.kind, c < 8 ? SRC_SINGLE : c == 30 ? SRC_BANDGAP :
                c == 31 ? SRC_GROUND : SRC_DIFF);
            if (c < 8) begin
                chk(route.pos, c[2:0]);
            end else if (c < 30) begin
                chk(route.gain, c[4] ? GAIN_1X :
                    (c[1] ? GAIN_200X : GAIN_10X));
                chk(route.pos, c[4] ? c[2:0] : {c[2], c[0]});
                chk(route.neg, c[4] ? (c[3] ? 2 : 1) : (c[2] ? 2 : 0));
            end
        end
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_IRQ_STAT, 8'h07);
        wr(ADDR_CTRL, 8'hd7);
        wb(1'b1);
        wr(ADDR_CTRL, 8'h00);
        wb(1'b0);
        rd(ADDR_CTRL, 8'h00);
        chk(32'(blen < 400), YES);
        chk(pwr, 32'h0000_0000);
        rd(ADDR_IRQ_STAT, 8'h02);
        wr(ADDR_IRQ_MASK, 8'h02);
        repeat (2) @(negedge sys_clk_in);
        chk(irq, YES);
        wr(ADDR_IRQ_STAT, 8'h02);
        repeat (2) @(negedge sys_clk_in);
        chk(irq, 32'h0000_0000);
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_CTRL, 8'h88);
        wr(ADDR_CTRL, 8'hc8);
        conv();
        chk(irq, 32'h0000_0000);
        @(posedge sys_clk_in) gie <= 1'b1;
        repeat (2) @(negedge sys_clk_in);
        chk(irq, YES);
        @(posedge sys_clk_in) ack <= 1'b1;
        @(posedge sys_clk_in) ack <= 1'b0;
        repeat (2) @(negedge sys_clk_in);
        chk(irq, 32'h0000_0000);
        rd(ADDR_CTRL, 8'h88);
        wr(ADDR_CTRL, 8'hc8);
        conv();
        chk(irq, YES);
        wr(ADDR_CTRL, 8'h98);
        rd(ADDR_CTRL, 8'h88);
        chk(irq, 32'h0000_0000);
        wr(ADDR_TRIGSEL, 8'h01);
        wr(ADDR_CTRL, 8'ha0);
        n0 = nconv;
        @(posedge sys_clk_in) flags <= 8'h02;
        conv();
        chk(nconv, n0 + 1);
        @(posedge sys_clk_in) flags <= 8'h04;
        wr(ADDR_TRIGSEL, 8'h02);
        conv();
        chk(nconv, n0 + 2);
        wr(ADDR_TRIGSEL, 8'h00);
        repeat (30) @(negedge sys_clk_in);
        chk(nconv, n0 + 2);
        wr(ADDR_CTRL, 8'he0);
        repeat (150) @(negedge sys_clk_in);
        chk(32'(nconv - n0 >= 6), YES);
        wr(ADDR_CTRL, 8'h00);
        r1 = 10'($urandom);
        r2 = ~r1;
        res <= r1;
        wr(ADDR_CTRL, 8'hc0);
        conv();
        rd(ADDR_RES_LOW, r1[7:0]);
        res <= r2;
        wr(ADDR_CTRL, 8'hc0);
        conv();
        rd(ADDR_RES_HIGH, 8'(r1[9:8]));
        bus(1'b0, ADDR_IRQ_STAT, 8'h00, rv);
        chk(rv[IRQ_OVERRUN], YES);
        wr(ADDR_CTRL, 8'hc0);
        conv();
        rd(ADDR_RES_LOW, r2[7:0]);
        chk(nsmp, nconv);
        results();
    end
endmodule // tb_adc_conversion_control
